// ---- hw/sensor_status_data_regs.sv ----
// Module: status and data register bank with read port queue, AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
// Overview
// Read-only status bank with one
// writable interrupt mask.
// Each register is one byte in
// bits 7:0 of a 32-bit word.
// Upper rdata bits read zero.
// Address bits 1:0 are ignored.
//
// Read timing
// Request taken when arvalid
// and arready are both high.
// Answer stands a cycle later
// and holds until rready.
// Side effects land at the
// answer handshake only.
//
// Write timing
// Address and data any order.
// Response one cycle after both.
// Only the mask takes a write.
// Status bytes answer SLVERR.
// Holes answer DECERR, but 0x23 answers SLVERR.
//
// Queue
// Bytes enter from the core.
// Bytes leave through one port.
// Fill count tracks bytes held.
// Full stalls the core.
//
// Limitation: a stalled read
// delays every clear-on-read.
module sensor_status_data_regs #(
    parameter logic [25:0] TICK_PS = sensor_status_pkg::TIME_TICK_PS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sensor_status_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [sensor_status_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sensor_status_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [sensor_status_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sensor_status_pkg::fill_type fill,
    output logic fill_ready,
    input wire sensor_status_pkg::core_type core,
    output logic irq
);
    import sensor_status_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    state_type s_reg; // Registered state
    state_type s_next; // Next state
    logic [7:0] queue_mem [QUEUE_DEPTH]; // Queue storage, no reset needed
    logic push; // Byte enters the queue
    logic pop; // Byte leaves at read completion
    logic r_done; // Read answer taken by master
    logic [26:0] acc_sum; // Time accumulator plus one clock
    logic [5:0] rd_idx; // Decoded read index
    logic [5:0] wr_idx; // Decoded write index
    logic [7:0] clr_flags; // Flags cleared this cycle
    logic [7:0] set_flags; // Flags raised this cycle
    logic clr_por; // Power-up flag cleared this cycle

    ////////////////////////////////////////////////////////////////////////
    // Index decode helper
    // Shared by read and write,
    // so both decode the same.
    // Byte lanes not decoded;
    // any byte of a word reaches
    // the same register.
    // Six index bits cover the
    // whole 8-bit address space.
    // No address bits exist
    // above bit 7 on this bus.
    // Word index from a byte address; low two bits are ignored
    function automatic logic [5:0] addr_index(
        input logic [ADDR_W-1:0] addr
    );
        addr_index = addr[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Handshake outputs and data outputs
    // Readies are plain gates on
    // the held state, so the bus
    // sees them the same cycle.
    // arready low while an answer
    // waits: one read in flight.
    // awready and wready drop once
    // their half is held, or
    // while the response waits.
    // Data outputs come straight
    // from the state register.
    // One read and one write at most in flight, so ready drops while busy
    assign s_axi_arready = !s_reg.rvalid;
    assign s_axi_awready = !s_reg.aw_hold && !s_reg.bvalid;
    assign s_axi_wready = !s_reg.w_hold && !s_reg.bvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign irq = s_reg.irq;
    // Back-pressure to the core once the queue is full
    assign fill_ready = (s_reg.count != COUNT_W'(QUEUE_DEPTH));

    ////////////////////////////////////////////////////////////////////////
    // Shared strobes
    assign r_done = s_reg.rvalid && s_axi_rready;
    assign push = fill.valid && fill_ready;
    assign pop = r_done && s_reg.rd_pop;
    assign rd_idx = addr_index(s_axi_araddr);
    assign wr_idx = addr_index(s_reg.aw_addr);
    // Clearing at the request would
    // lose an event that lands
    // while the host stalls rready.
    // The request records what it
    // returned, and the handshake
    // removes just that.
    // An event in that window
    // stays for the next read.
    // Clears take effect only at the read answer handshake
    assign clr_flags = r_done ? s_reg.rd_clr_flags : 8'h00;
    assign clr_por = r_done && s_reg.rd_clr_por;

    ////////////////////////////////////////////////////////////////////////
    // Event collection into the flag layout
    always_comb begin
        set_flags = 8'h00;
        set_flags[BIT_ACC_DRDY] = core.acc_drdy;
        set_flags[BIT_AUX_DRDY] = core.aux_drdy;
        set_flags[BIT_WATERMARK] = core.watermark;
        // Core events are one-cycle
        // pulses; each sets its bit.
        // Reserved bits never set.
        // Full comes from the push
        // that fills the last slot,
        // not while full persists.
        // Full event when the last free byte is taken
        set_flags[BIT_QUEUE_FULL] = push && !pop &&
            (s_reg.count == COUNT_W'(QUEUE_DEPTH - 1));
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        s_next = s_reg;

        // Time base: picosecond accumulator keeps the fractional period
        // exact over the long run; a tick jitters by one clock
        acc_sum = {1'b0, s_reg.tacc} + {1'b0, CLK_PERIOD_PS};
        if (acc_sum >= {1'b0, TICK_PS}) begin
            s_next.tacc = 26'(acc_sum - {1'b0, TICK_PS});
            s_next.tcount = s_reg.tcount + 24'h000001;
        end else begin
            s_next.tacc = acc_sum[25:0];
        end

        // The set term is ORed after
        // the clear term, so an event
        // and a clear in one cycle
        // leave the bit set.
        // Soft reset raises the
        // power-up flag as a reset
        // does, without touching
        // other state.
        // Sticky flags: a set in the clearing cycle survives
        s_next.irq_flags = (s_reg.irq_flags & ~clr_flags) | set_flags;
        s_next.por = (s_reg.por & ~clr_por) | core.soft_reset;

        // Queue pointers and fill count
        if (push) begin
            s_next.wr_ptr = s_reg.wr_ptr + PTR_W'(1);
        end
        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + PTR_W'(1);
        end
        // Pointers wrap at the depth;
        // the count tells full from
        // empty, so the pointers need
        // no extra bit.
        // Push and pop together
        // leave the count unchanged.
        // Count follows every push and pop in the same cycle
        case ({push, pop})
            2'b10: s_next.count = s_reg.count + COUNT_W'(1);
            2'b01: s_next.count = s_reg.count - COUNT_W'(1);
            default: s_next.count = s_reg.count;
        endcase

        // Read answer retires on handshake
        if (r_done) begin
            s_next.rvalid = 1'b0;
            s_next.rd_clr_flags = 8'h00;
            s_next.rd_clr_por = 1'b0;
            s_next.rd_pop = 1'b0;
        end

        // The retire above runs first;
        // a new request in the same
        // cycle would win, but the
        // ready gate prevents that.
        // Each request starts from a
        // zero word and okay status.
        // Decode follows the map,
        // low to high, 0x1D before 0x1C.
        // Read request: data captured now, side effects at completion
        if (s_axi_arvalid && s_axi_arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            s_next.rdata = '0;
            s_next.rd_clr_flags = 8'h00;
            s_next.rd_clr_por = 1'b0;
            s_next.rd_pop = 1'b0;
            if (rd_idx == IDX_ACCEL_Z_HIGH) begin
                s_next.rdata[7:0] = core.accel_z_high;
            end else if (rd_idx == IDX_TIME_LOW) begin
                s_next.rdata[7:0] = s_reg.tcount[7:0];
            end else if (rd_idx == IDX_TIME_MID) begin
                s_next.rdata[7:0] = s_reg.tcount[15:8];
            end else if (rd_idx == IDX_TIME_HIGH) begin
                s_next.rdata[7:0] = s_reg.tcount[23:16];
            end else if (rd_idx == IDX_POWER_UP_EVENT) begin
                // Reserved bits read zero
                s_next.rdata[0] = s_reg.por;
                s_next.rd_clr_por = s_reg.por;
            end else if (rd_idx == IDX_DATA_FIFO_IRQ) begin
                // Only the bits returned are cleared later
                s_next.rdata[7:0] = s_reg.irq_flags & IRQ_USED_BITS;
                s_next.rd_clr_flags = s_reg.irq_flags;
            end else if (rd_idx == IDX_FEATURE_IRQ ||
                         (rd_idx >= IDX_STRIDE_FIRST &&
                          rd_idx <= IDX_STRIDE_LAST)) begin
                // Feature results live elsewhere; read as zero here
                s_next.rdata = '0;
            end else if (rd_idx == IDX_DIE_TEMP) begin
                // Signed code passed through unchanged
                s_next.rdata[7:0] = core.temperature;
            end else if (rd_idx == IDX_QUEUE_FILL_LOW) begin
                s_next.rdata[7:0] = s_reg.count[7:0];
            end else if (rd_idx == IDX_QUEUE_FILL_HIGH) begin
                // Bits 7 and 6 reserved, read zero
                s_next.rdata[5:0] = s_reg.count[13:8];
            end else if (rd_idx == IDX_QUEUE_READ_PORT) begin
                // Empty queue returns zero and removes nothing
                if (s_reg.count != '0) begin
                    s_next.rdata[7:0] = queue_mem[s_reg.rd_ptr];
                    s_next.rd_pop = 1'b1;
                end
            end else if (rd_idx == IDX_IRQ_MASK) begin
                s_next.rdata[7:0] = s_reg.mask;
            end else begin
                s_next.rresp = RESP_DECERR;
            end
        end

        // Each half is latched on its
        // own handshake and held
        // until the other arrives.
        // One write in flight: both
        // readies stay low until the
        // response is taken.
        // Write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_hold = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_hold = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end

        // Write response retires on handshake
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Both halves held: perform the write and answer
        if (s_reg.aw_hold && s_reg.w_hold && !s_reg.bvalid) begin
            s_next.aw_hold = 1'b0;
            s_next.w_hold = 1'b0;
            s_next.bvalid = 1'b1;
            if (wr_idx == IDX_IRQ_MASK) begin
                s_next.bresp = RESP_OKAY;
                if (s_reg.w_strb[0]) begin
                    s_next.mask = s_reg.w_data[7:0] & IRQ_USED_BITS;
                end
            end else if (wr_idx >= IDX_ACCEL_Z_HIGH &&
                         wr_idx <= IDX_QUEUE_READ_PORT) begin
                // Status and data registers cannot be written
                s_next.bresp = RESP_SLVERR;
            end else begin
                s_next.bresp = RESP_DECERR;
            end
        end

        // Interrupt uses the next
        // flag and mask values, so
        // the pin rises with the flag
        // it reports and falls with
        // the clear that removes it.
        // Level interrupt from any unmasked flag
        s_next.irq = |(s_next.irq_flags & s_next.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // Whole state moves in one
    // register; reset is seen
    // on the clock edge only.
    // Reset leaves the power-up
    // flag set, all else clear.
    // Time starts from zero.
    // State register; synchronous reset doubles as power-on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.por <= POWER_UP_EVENT_RESET[0];
            s_reg.irq_flags <= IRQ_FLAGS_RESET;
            s_reg.mask <= IRQ_MASK_RESET;
            s_reg.tcount <= TIME_COUNT_RESET;
            s_reg.bresp <= RESP_OKAY;
            s_reg.rresp <= RESP_OKAY;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storage has no reset: bytes
    // beyond the fill count are
    // never returned.
    // Read side is a plain index
    // into the array.
    // Queue storage write port
    always_ff @(posedge aclk) begin
        if (push) begin
            queue_mem[s_reg.wr_ptr] <= fill.data;
        end
    end

endmodule
`default_nettype wire

// ---- hw/sensor_status_pkg.sv ----
// Package: register map, field layout, timing and state types of the bank
package sensor_status_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register indexes as printed; byte address is four times the index
    localparam logic [5:0] IDX_ACCEL_Z_HIGH = 6'h17;
    localparam logic [5:0] IDX_TIME_LOW = 6'h18;
    localparam logic [5:0] IDX_TIME_MID = 6'h19;
    localparam logic [5:0] IDX_TIME_HIGH = 6'h1A;
    localparam logic [5:0] IDX_POWER_UP_EVENT = 6'h1B;
    localparam logic [5:0] IDX_FEATURE_IRQ = 6'h1C;
    localparam logic [5:0] IDX_DATA_FIFO_IRQ = 6'h1D;
    localparam logic [5:0] IDX_STRIDE_FIRST = 6'h1E;
    localparam logic [5:0] IDX_STRIDE_LAST = 6'h21;
    localparam logic [5:0] IDX_DIE_TEMP = 6'h22;
    localparam logic [5:0] IDX_QUEUE_FILL_LOW = 6'h24;
    localparam logic [5:0] IDX_QUEUE_FILL_HIGH = 6'h25;
    localparam logic [5:0] IDX_QUEUE_READ_PORT = 6'h26;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h30;

    // Field positions in the interrupt flag byte
    localparam int BIT_ACC_DRDY = 7;
    localparam int BIT_AUX_DRDY = 5;
    localparam int BIT_WATERMARK = 1;
    localparam int BIT_QUEUE_FULL = 0;
    localparam logic [7:0] IRQ_USED_BITS = 8'hA3;

    // Reset values
    localparam logic [7:0] POWER_UP_EVENT_RESET = 8'h01;
    localparam logic [7:0] IRQ_FLAGS_RESET = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [23:0] TIME_COUNT_RESET = 24'h000000;

    // Time base: tick period in picoseconds against the clock period
    localparam logic [25:0] TIME_TICK_PS = 26'd39062500;
    localparam logic [25:0] CLK_PERIOD_PS = 26'd10000;

    // Queue geometry: 1 kbyte, 14-bit fill counter
    localparam int QUEUE_DEPTH = 1024;
    localparam int PTR_W = 10;
    localparam int COUNT_W = 14;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // Fill-side stream from the sensor core
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } fill_type;

    // Events and samples from the sensor core
    typedef struct packed {
        logic acc_drdy;
        logic aux_drdy;
        logic watermark;
        logic soft_reset;
        logic [7:0] accel_z_high;
        logic [7:0] temperature;
    } core_type;

    // Complete state of the bank
    typedef struct packed {
        logic aw_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic w_hold;
        logic [DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [7:0] rd_clr_flags;
        logic rd_clr_por;
        logic rd_pop;
        logic [7:0] irq_flags;
        logic por;
        logic [7:0] mask;
        logic [23:0] tcount;
        logic [25:0] tacc;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [COUNT_W-1:0] count;
        logic irq;
    } state_type;

endpackage

// ---- verif/host_bus_model.sv ----
// Host model: AXI4-Lite master issuing one access at a time
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
    input wire logic aclk,
    output var logic [7:0] awaddr,
    output var logic awvalid,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    output var logic wvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output var logic bready,
    output var logic [7:0] araddr,
    output var logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output var logic rready
);
    // Idle bus from time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Write: halves offered together; released lines show inverted data
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} <= {a, 1'b1, d, 6'h3F};
        do begin
            @(posedge aclk);
            if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
            if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~d};
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    // Read: each port read is one byte, address inverted once taken
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
        end while (!rvalid);
        {d, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/sensor_status_data_regs_chk.sv ----
// Checker: bus timing and read-data relations of the register bank
`timescale 1ns/1ns
`default_nettype none
module sensor_status_data_regs_chk
    import sensor_status_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sensor_status_pkg::core_type core
);
    // One domain, so one clock and one reset for all
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    property p_ar_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ar_answer: assert property (p_ar_answer)
        else $error("read taken but no answer next cycle");
    // Data must not move while the host stalls, or a flag could be lost
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data moved before acceptance");
    property p_r_single;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_single: assert property (p_r_single)
        else $error("second answer without request");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    // Read-only bytes refuse writes with an error response
    property p_ro_write;
        s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:2] == IDX_TIME_LOW
        |-> ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to time byte not refused");
    property p_temp;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == IDX_DIE_TEMP
        |=> s_axi_rdata[7:0] == $past(core.temperature);
    endproperty
    a_temp: assert property (p_temp)
        else $error("temperature byte not passed through");
    property p_fill_high;
        s_axi_arvalid && s_axi_arready
        && s_axi_araddr[7:2] == IDX_QUEUE_FILL_HIGH |=> s_axi_rdata[7:6] == 2'h0;
    endproperty
    a_fill_high: assert property (p_fill_high)
        else $error("reserved fill bits set");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h3F
        |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not decode error");
endmodule
bind sensor_status_data_regs sensor_status_data_regs_chk
    u_sensor_status_data_regs_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .core(core));
`default_nettype wire

// ---- verif/test_sensor_status_data_regs.sv ----
// Bench: register reads, queue traffic and event flags of the bank
`timescale 1ns/1ns
`default_nettype none
module test_sensor_status_data_regs;
    import sensor_status_pkg::*;
    logic aclk, aresetn, fill_ready, irq, awready, wready, bvalid, arready;
    logic rvalid, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr, t0;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp_v;
    fill_type fill;
    core_type core;
    int error_cnt, comparisons, cyc;
    // Clock of 10 ns
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // Short tick period: one time step every 5 cycles
    sensor_status_data_regs #(.TICK_PS(26'd50000)) u_sensor_status_data_regs (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_rready(rready),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .fill(fill), .fill_ready(fill_ready),
        .core(core), .irq(irq));
    host_bus_model u_host_bus_model (.aclk(aclk), .awaddr(awaddr),
        .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .rready(rready),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [33:0] e,
                       input logic [33:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Read one register index, expect an okay answer and a value
    task automatic rchk(input string n, input logic [5:0] i,
                        input logic [31:0] e);
        u_host_bus_model.rd({i, 2'b00}, rd_v, resp_v);
        chk(n, {RESP_OKAY, e}, {resp_v, rd_v});
    endtask
    // One-cycle event pulse from the sensor core
    task automatic pulse(input logic [19:0] m);
        @(posedge aclk);
        core <= core | m;
        @(posedge aclk);
        core <= core & ~m;
    endtask
    // Back-to-back bytes into the queue; stalls while full
    task automatic push(input int n);
        @(posedge aclk);
        for (int i = 0; i < n; i++) begin
            fill <= {1'b1, i[7:0] ^ 8'hA5};
            do @(posedge aclk); while (!fill_ready);
        end
        fill <= {1'b0, 8'h5A};
    endtask
    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, fill, cyc, error_cnt, comparisons} = '0;
        core = {4'h0, 8'h5A, 8'hE7};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("power_up", IDX_POWER_UP_EVENT, POWER_UP_EVENT_RESET);
        rchk("power_up_clr", IDX_POWER_UP_EVENT, 32'h0);
        rchk("irq_flags", IDX_DATA_FIFO_IRQ, IRQ_FLAGS_RESET);
        rchk("time_high", IDX_TIME_HIGH, 32'h0);
        rchk("accel_z", IDX_ACCEL_Z_HIGH, 32'h5A);
        rchk("temp", IDX_DIE_TEMP, 32'hE7);
        // Same-length reads 50 cycles apart: ten ticks
        u_host_bus_model.rd({IDX_TIME_LOW, 2'b00}, rd_v, resp_v);
        t0 = rd_v[7:0] + 8'd10;
        repeat (47) @(posedge aclk);
        rchk("time_low", IDX_TIME_LOW, {24'h0, t0});
        pulse(20'h20000);
        rchk("watermark", IDX_DATA_FIFO_IRQ, 32'h1 << BIT_WATERMARK);
        pulse(20'h80000);
        // Second event lands on the clearing edge and must survive
        fork
            rchk("acc_drdy", IDX_DATA_FIFO_IRQ, 32'h1 << BIT_ACC_DRDY);
            begin
                @(posedge aclk);
                pulse(20'h40000);
            end
        join
        rchk("aux_kept", IDX_DATA_FIFO_IRQ, 32'h1 << BIT_AUX_DRDY);
        rchk("flags_clr", IDX_DATA_FIFO_IRQ, 32'h0);
        u_host_bus_model.wr({IDX_IRQ_MASK, 2'b00}, 32'h80, resp_v);
        chk("mask_resp", RESP_OKAY, resp_v);
        pulse(20'h40000);
        repeat (3) @(posedge aclk);
        chk("irq_masked", 32'h0, irq);
        pulse(20'h80000);
        repeat (3) @(posedge aclk);
        chk("irq_set", 32'h1, irq);
        rchk("both_flags", IDX_DATA_FIFO_IRQ, 32'hA0);
        repeat (3) @(posedge aclk);
        chk("irq_clr", 32'h0, irq);
        u_host_bus_model.wr({IDX_TIME_LOW, 2'b00}, 32'hFF, resp_v);
        chk("ro_write", RESP_SLVERR, resp_v);
        u_host_bus_model.rd(8'hFC, rd_v, resp_v);
        chk("unmapped", {RESP_DECERR, 32'h0}, {resp_v, rd_v});
        push(3);
        rchk("fill_low", IDX_QUEUE_FILL_LOW, 32'h3);
        rchk("fill_high", IDX_QUEUE_FILL_HIGH, 32'h0);
        for (int i = 0; i < 3; i++) rchk("pop", IDX_QUEUE_READ_PORT, i ^ 8'hA5);
        rchk("fill_empty", IDX_QUEUE_FILL_LOW, 32'h0);
        rchk("pop_empty", IDX_QUEUE_READ_PORT, 32'h0);
        push(1024);
        @(posedge aclk);
        chk("full_stall", 32'h0, fill_ready);
        rchk("fill_full", IDX_QUEUE_FILL_HIGH, 32'h4);
        rchk("full_flag", IDX_DATA_FIFO_IRQ, 32'h1 << BIT_QUEUE_FULL);
        rchk("pop_first", IDX_QUEUE_READ_PORT, 32'hA5);
        rchk("fill_dec_lo", IDX_QUEUE_FILL_LOW, 32'hFF);
        rchk("fill_dec_hi", IDX_QUEUE_FILL_HIGH, 32'h3);
        pulse(20'h10000);
        rchk("soft_reset", IDX_POWER_UP_EVENT, 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
